// file: include/cef_consts.svh
// Register indices, field positions, reset and force values of the event flags
`ifndef CEF_CONSTS_SVH
`define CEF_CONSTS_SVH

`define CEF_DATA_W      8
`define CEF_IDX_W       4
`define CEF_NUM_REGS    4'h4
`define CEF_IDX_CTRL    4'h0
`define CEF_IDX_CMD     4'h1
`define CEF_IDX_STATE   4'h2
`define CEF_IDX_FLAGS   4'h3

`define CEF_RESP_OKAY   2'h0
`define CEF_RESP_DECERR 2'h3

// control_reg fields
`define CEF_CR_RST      0
`define CEF_CR_RX_EN    1
`define CEF_CR_TX_EN    2
`define CEF_CR_FAULT_EN 3
`define CEF_CR_OVF_EN   4
`define CEF_CR_REF_ON   5
`define CEF_CR_DIAG     7
`define CEF_CR_RESET    8'h21
`define CEF_CR_FORCE0   8'h80
`define CEF_CR_RMASK    8'hbf

// command_reg fields
`define CEF_CMD_SEND    0
`define CEF_CMD_CANCEL  1
`define CEF_CMD_RXREL   2
`define CEF_CMD_OVFCLR  3
`define CEF_CMD_SLEEP   4
`define CEF_CMD_LINE1   6
`define CEF_CMD_LINE0   7
`define CEF_CMD_RESET   8'hcc
`define CEF_CMD_FORCE0  8'h13
`define CEF_CMD_FORCE1  8'h0c
`define CEF_CMD_RMASK   8'hdf

// event_flag_reg fields
`define CEF_FLAG_W      5
`define CEF_FL_RX       0
`define CEF_FL_TX       1
`define CEF_FL_FAULT    2
`define CEF_FL_OVF      3
`define CEF_FL_WAKE     4
`define CEF_FL_FORCE0   5'h0b

// Low six state_reg bits while reset request is high
`define CEF_SR_FORCED   6'h0c

`define CEF_BUSFREE_CNT 128

`endif

// file: include/cef_pkg.sv
// Types shared by the event flag block and its register slave
package cef_pkg;
`include "cef_consts.svh"

    typedef struct packed {
        logic                    wr;
        logic [`CEF_IDX_W-1:0]   wr_idx;
        logic [`CEF_DATA_W-1:0]  wdata;
        logic                    rd;
        logic [`CEF_IDX_W-1:0]   rd_idx;
    } cef_reg_req_t;

    typedef struct packed {
        logic send_active;
        logic frame_incoming;
        logic tx_release;
        logic tx_done;
        logic rx_msg_avail;
        logic overrun_event;
        logic warn_level;
        logic bus_off_enter;
        logic bus_free;
    } cef_core_in_t;

    typedef enum logic [0:0] {
        CEF_REC_IDLE = 1'b0,
        CEF_REC_WAIT = 1'b1
    } cef_rec_t;

endpackage

// file: rtl/cef_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
`include "cef_consts.svh"

module cef_axil_slave #(
    parameter int ADDR_W = 8
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [ADDR_W-1:0]       s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output cef_pkg::cef_reg_req_t        req,
    input  wire logic [`CEF_DATA_W-1:0]  rd_data
);

    logic wr_go;
    logic rd_go;
    logic wr_hit;
    logic rd_hit;

    // Word index must fall inside the register map, upper bits included
    assign wr_hit = (s_axi_awaddr[ADDR_W-1:2] < (ADDR_W-2)'(`CEF_NUM_REGS));
    assign rd_hit = (s_axi_araddr[ADDR_W-1:2] < (ADDR_W-2)'(`CEF_NUM_REGS));

    // Address and data are taken together once no response is pending
    assign s_axi_awready = s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_wready  = s_axi_awvalid & ~s_axi_bvalid;
    assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;

    assign req.wr     = wr_go & wr_hit & s_axi_wstrb[0];
    assign req.wr_idx = s_axi_awaddr[`CEF_IDX_W+1:2];
    assign req.wdata  = s_axi_wdata[`CEF_DATA_W-1:0];
    assign req.rd     = rd_go & rd_hit;
    assign req.rd_idx = s_axi_araddr[`CEF_IDX_W+1:2];

    // ==========================================================
    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CEF_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `CEF_RESP_OKAY : `CEF_RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Read data, captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `CEF_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_hit ? {24'h0, rd_data} : 32'h0;
            s_axi_rresp  <= rd_hit ? `CEF_RESP_OKAY : `CEF_RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// file: rtl/cef_event_flags.sv
// Event flag register, reset request effects and bus-off recovery
// How it works
// R1: Interrupt line is high whenever any event flag bit is set.
// R2: Any CPU read of the event flag register clears all its flags.
// R3: Event flags sit at index 3, read only, bits 4..0, top reserved.
// R4: Wake flag (bit 4) sets when the controller leaves sleep.
// R5: Overflow flag (bit 3) sets, if enabled, on overrun of full buffers.
// R6: Fault flag (bit 2) sets, if enabled, on link-off or warning change.
// R7: Transmit flag (bit 1) sets, if enabled, on buffer-free rising.
// R8: Receive flag (bit 0) sets, if enabled, on new received message.
// R9: Overflow flag and overrun status set in the same cycle.
// R10: Receive flag and receive-full status set in the same cycle.
// R11: Reset request forces diag off, sleep/cancel/send low, clears high.
// R12: Reset request forces idle, finished, free, clear statuses and clears the receive, transmit and overflow flags.
// R13: External reset drives reference output and both line selects high.
// R14: External reset clears link-off and error-warning statuses.
// R15: After bus-off and reset request cleared, wait 128 bus-free events.
// R16: Bus-off entry raises reset request until the CPU writes it low.
// R17: Reserved flag bits read zero and writing the register has no effect.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "cef_consts.svh"

module cef_event_flags #(
    parameter int ADDR_W     = 8,
    parameter int BUSFREE_N  = `CEF_BUSFREE_CNT
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [ADDR_W-1:0]       s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire cef_pkg::cef_core_in_t   core,
    output logic [`CEF_DATA_W-1:0]       control_reg,
    output logic [`CEF_DATA_W-1:0]       command_reg,
    output logic [`CEF_DATA_W-1:0]       state_reg,
    output logic                         counter_reset,
    output logic                         can_irq_line
);

    localparam int CNT_W = $clog2(BUSFREE_N + 1);

    cef_pkg::cef_reg_req_t        req;
    cef_pkg::cef_rec_t            rec_q;
    logic [`CEF_DATA_W-1:0]       rd_data;
    logic [`CEF_DATA_W-1:0]       cr_q;
    logic [`CEF_DATA_W-1:0]       cr_d;
    logic [`CEF_DATA_W-1:0]       cmd_q;
    logic [`CEF_DATA_W-1:0]       cmd_d;
    logic [`CEF_FLAG_W-1:0]       flag_q;
    logic [`CEF_FLAG_W-1:0]       flag_d;
    logic [`CEF_FLAG_W-1:0]       flag_set;
    logic [CNT_W-1:0]             cnt_q;
    logic                         rst_req;
    logic                         wr_cr;
    logic                         wr_cmd;
    logic                         rd_flags;
    logic                         last_free;
    logic                         sa_q;
    logic                         fi_q;
    logic                         tfin_q;
    logic                         tbf_q;
    logic                         tbf_d;
    logic                         ovr_q;
    logic                         rxf_q;
    logic                         off_q;
    logic                         off_d;
    logic                         ew_q;
    logic                         ew_d;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    cef_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_slave (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .req           (req),
        .rd_data       (rd_data)
    );

    // ==========================================================
    // Register decode
    assign rst_req  = cr_q[`CEF_CR_RST];
    assign wr_cr    = req.wr && (req.wr_idx == `CEF_IDX_CTRL);
    assign wr_cmd   = req.wr && (req.wr_idx == `CEF_IDX_CMD);
    assign rd_flags = req.rd && (req.rd_idx == `CEF_IDX_FLAGS);   // R2

    assign control_reg = cr_q;
    assign command_reg = cmd_q;
    assign state_reg   = {off_q, ew_q, sa_q, fi_q,
                          tfin_q, tbf_q, ovr_q, rxf_q};

    always_comb begin
        unique case (req.rd_idx)
            `CEF_IDX_CTRL:  rd_data = cr_q & `CEF_CR_RMASK;
            `CEF_IDX_CMD:   rd_data = cmd_q & `CEF_CMD_RMASK;
            `CEF_IDX_STATE: rd_data = state_reg;
            `CEF_IDX_FLAGS: rd_data = {3'h0, flag_q};             // R3 R17
            default:        rd_data = 8'h0;
        endcase
    end

    // ==========================================================
    // Control register: reset request, enables, diag mode
    always_comb begin
        cr_d = wr_cr ? req.wdata : cr_q;
        if (core.bus_off_enter) begin
            cr_d[`CEF_CR_RST] = 1'b1;                               // R16
        end
        if (rst_req) begin
            cr_d = cr_d & ~`CEF_CR_FORCE0;                          // R11
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cr_q <= `CEF_CR_RESET;                                  // R13
        end else begin
            cr_q <= cr_d;
        end
    end

    // ==========================================================
    // Command register
    always_comb begin
        cmd_d = wr_cmd ? req.wdata : cmd_q;
        if (rst_req) begin
            cmd_d = (cmd_d & ~`CEF_CMD_FORCE0) | `CEF_CMD_FORCE1;  // R11
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_q <= `CEF_CMD_RESET;                                // R13
        end else begin
            cmd_q <= cmd_d;
        end
    end

    // ==========================================================
    // Status bits
    always_comb begin
        tbf_d = tbf_q;
        if (rst_req || core.tx_release) begin
            tbf_d = 1'b1;
        end else if (wr_cmd && req.wdata[`CEF_CMD_SEND]) begin
            tbf_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sa_q   <= 1'b0;
            fi_q   <= 1'b0;
            tfin_q <= 1'b1;
            tbf_q  <= 1'b1;
            ovr_q  <= 1'b0;
            rxf_q  <= 1'b0;
        end else if (rst_req) begin                                 // R12
            sa_q   <= 1'b0;
            fi_q   <= 1'b0;
            tfin_q <= 1'b1;
            tbf_q  <= 1'b1;
            ovr_q  <= 1'b0;
            rxf_q  <= 1'b0;
        end else begin
            sa_q  <= core.send_active;
            fi_q  <= core.frame_incoming;
            tbf_q <= tbf_d;
            if (core.tx_done) begin
                tfin_q <= 1'b1;
            end else if (wr_cmd && req.wdata[`CEF_CMD_SEND]) begin
                tfin_q <= 1'b0;
            end
            if (core.overrun_event) begin
                ovr_q <= 1'b1;                                      // R9
            end else if (wr_cmd && req.wdata[`CEF_CMD_OVFCLR]) begin
                ovr_q <= 1'b0;
            end
            if (core.rx_msg_avail) begin
                rxf_q <= 1'b1;                                      // R10
            end else if (wr_cmd && req.wdata[`CEF_CMD_RXREL]) begin
                rxf_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Link-off and error warning with bus-free recovery
    assign last_free = (rec_q == cef_pkg::CEF_REC_WAIT) && core.bus_free
                       && (cnt_q == CNT_W'(BUSFREE_N - 1));

    assign off_d = core.bus_off_enter ? 1'b1 : (last_free ? 1'b0 : off_q);
    assign ew_d  = last_free ? 1'b0 : core.warn_level;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            off_q <= 1'b0;                                          // R14
            ew_q  <= 1'b0;                                          // R14
        end else begin
            off_q <= off_d;                                         // R15
            ew_q  <= ew_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rec_q <= cef_pkg::CEF_REC_IDLE;
            cnt_q <= '0;
        end else begin
            unique case (rec_q)
                cef_pkg::CEF_REC_IDLE: begin
                    cnt_q <= '0;
                    if (off_q && !rst_req) begin
                        rec_q <= cef_pkg::CEF_REC_WAIT;             // R15
                    end
                end
                cef_pkg::CEF_REC_WAIT: begin
                    if (rst_req || last_free) begin
                        rec_q <= cef_pkg::CEF_REC_IDLE;
                        cnt_q <= '0;
                    end else if (core.bus_free) begin
                        cnt_q <= cnt_q + CNT_W'(1);                 // R15
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_reset <= 1'b0;
        end else begin
            counter_reset <= last_free;                             // R15
        end
    end

    // ==========================================================
    // Event flags
    always_comb begin
        flag_set = '0;
        flag_set[`CEF_FL_WAKE]  = cmd_q[`CEF_CMD_SLEEP]
                                  & ~cmd_d[`CEF_CMD_SLEEP];         // R4
        flag_set[`CEF_FL_OVF]   = cr_q[`CEF_CR_OVF_EN]
                                  & core.overrun_event;             // R5
        flag_set[`CEF_FL_FAULT] = cr_q[`CEF_CR_FAULT_EN]
                                  & ((off_d ^ off_q) | (ew_d ^ ew_q)); // R6
        flag_set[`CEF_FL_TX]    = cr_q[`CEF_CR_TX_EN]
                                  & tbf_d & ~tbf_q;                 // R7
        flag_set[`CEF_FL_RX]    = cr_q[`CEF_CR_RX_EN]
                                  & core.rx_msg_avail;              // R8
        // A read clears, but an event in the same cycle survives
        flag_d = (flag_q & ~{`CEF_FLAG_W{rd_flags}}) | flag_set;    // R2
        if (rst_req) begin
            flag_d = flag_d & ~`CEF_FL_FORCE0;                      // R12
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign can_irq_line = |flag_q;                                  // R1

    // ==========================================================
    // Checks
    sequence s_last_free;
        rec_q == cef_pkg::CEF_REC_WAIT && core.bus_free
            && cnt_q == CNT_W'(BUSFREE_N - 1);
    endsequence

    sequence s_recovered;
        !off_q && !ew_q && counter_reset;
    endsequence

    a_irq_line_level: assert property (
        (flag_q != '0) |-> can_irq_line ##1 (flag_q == '0 || can_irq_line))
        else $error("irq line low with a flag set");                // R1
    a_read_clears: assert property (
        rd_flags && flag_set == '0 |=> flag_q == '0)
        else $error("flag read did not clear flags");               // R2
    a_reserved_zero: assert property (
        req.rd_idx == `CEF_IDX_FLAGS |-> rd_data[7:5] == 3'h0)
        else $error("reserved flag bits not zero");                 // R3 R17
    a_wake_set: assert property (
        $fell(cmd_q[`CEF_CMD_SLEEP]) |-> flag_q[`CEF_FL_WAKE])
        else $error("wake flag missing on sleep exit");             // R4
    a_overflow_pair: assert property (
        core.overrun_event && cr_q[`CEF_CR_OVF_EN] && !rst_req
            |=> ovr_q && flag_q[`CEF_FL_OVF])
        else $error("overflow flag not with overrun status");       // R5 R9
    a_fault_change: assert property (
        ($changed(off_q) || $changed(ew_q)) && $past(cr_q[`CEF_CR_FAULT_EN])
            && !$past(rst_req) |-> flag_q[`CEF_FL_FAULT])
        else $error("fault flag missing on status change");         // R6
    a_tx_rise: assert property (
        $rose(tbf_q) && $past(cr_q[`CEF_CR_TX_EN]) && !$past(rst_req)
            |-> flag_q[`CEF_FL_TX])
        else $error("tx flag missing on buffer free");              // R7
    a_rx_pair: assert property (
        core.rx_msg_avail && cr_q[`CEF_CR_RX_EN] && !rst_req
            |=> rxf_q && flag_q[`CEF_FL_RX])
        else $error("rx flag not with rx full status");             // R8 R10
    a_reset_cmds: assert property (
        rst_req |=> (cmd_q & `CEF_CMD_FORCE0) == 8'h0
            && (cmd_q & `CEF_CMD_FORCE1) == `CEF_CMD_FORCE1
            && !cr_q[`CEF_CR_DIAG])
        else $error("reset request did not force commands");        // R11
    a_reset_status: assert property (
        rst_req |=> state_reg[5:0] == `CEF_SR_FORCED
            && (flag_q & `CEF_FL_FORCE0) == 5'h0)
        else $error("reset request did not force status");          // R12
    a_ext_reset: assert property (disable iff (1'b0)
        !aresetn |=> cr_q[`CEF_CR_REF_ON] && cmd_q[`CEF_CMD_LINE0]
            && cmd_q[`CEF_CMD_LINE1] && !off_q && !ew_q)
        else $error("external reset values wrong");                 // R13 R14
    a_recovery_end: assert property (
        (s_last_free and !core.bus_off_enter) |=> s_recovered)
        else $error("recovery did not clear link-off");             // R15
    a_busoff_req: assert property (
        core.bus_off_enter |=> rst_req && off_q)
        else $error("bus-off did not raise reset request");         // R16

endmodule

// file: sim/cef_cpu_model.sv
// CPU register master model on the AXI4-Lite side of the flag block
`timescale 1ns/1ps
module cef_cpu_model (
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    int lag = 0;
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid,
             s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    initial s_axi_wstrb = 4'hf;
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= ~{a, 24'h0, d};
        {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
        repeat (lag) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(negedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        {s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
        repeat (lag) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
endmodule

// file: sim/can_event_flags_and_reset_effects_test.sv
// Self-checking bench for the CAN event flag block
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
    bad_count++; $display("Error %s exp %h got %h", n, e, a); end end
module can_event_flags_and_reset_effects_test;
    logic                  aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]            s_axi_awaddr, s_axi_araddr;
    logic [7:0]            control_reg, command_reg, state_reg;
    logic [31:0]           s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0]            s_axi_wstrb;
    logic [1:0]            s_axi_bresp, s_axi_rresp, rd_r;
    logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                  s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic                  s_axi_rready, counter_reset, can_irq_line;
    cef_pkg::cef_core_in_t core = '0;
    int                    bad_count = 0, samples_checked = 0, cycles = 0;
    always #2.5 aclk = ~aclk;
    cef_event_flags #(.BUSFREE_N(4)) cef_event_flags_inst (.*);
    cef_cpu_model cef_cpu_model_inst (.*);
    task automatic finish_test;
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge aclk) if (++cycles == 5000) begin
        bad_count++;
        finish_test;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cef_cpu_model_inst.wr(a, d, rd_r);
        `CHK("bresp", (a > 8'h0c) ? 2'h3 : 2'h0, rd_r)
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        cef_cpu_model_inst.rd(a, rd_d, rd_r);
        `CHK("rdata", {24'h0, e}, rd_d)
        `CHK("rresp", (a > 8'h0c) ? 2'h3 : 2'h0, rd_r)
    endtask
    // One-cycle event pulse on a core input, settled on return
    task automatic pulse(input int b);
        @(posedge aclk) core[b] <= 1'b1;
        @(posedge aclk) core[b] <= 1'b0;
        #1;
    endtask
    task automatic t_reset;
        cef_cpu_model_inst.lag = 2;
        rdc(8'h00, 8'h21);
        rdc(8'h04, 8'hcc);
        rdc(8'h08, 8'h0c);
        wr(8'h0c, 8'hff);
        rdc(8'h0c, 8'h00);
        wr(8'h10, 8'hff);
        rdc(8'h10, 8'h00);
        `CHK("irq", 1'b0, can_irq_line)
    endtask
    task automatic t_rx;
        wr(8'h00, 8'h00);
        pulse(4);
        `CHK("rx_full", 2'b10, {state_reg[0], can_irq_line})
        wr(8'h00, 8'h1e);
        pulse(4);
        `CHK("rx_full", 2'b11, {state_reg[0], can_irq_line})
        rdc(8'h0c, 8'h01);
        `CHK("irq", 1'b0, can_irq_line)
        pulse(3);
        `CHK("overrun", 2'b11, {state_reg[1], can_irq_line})
        rdc(8'h0c, 8'h08);
    endtask
    task automatic t_tx;
        wr(8'h04, 8'h01);
        `CHK("tx_free", 2'b00, state_reg[3:2])
        pulse(6);
        pulse(5);
        `CHK("tx_done", 2'b11, state_reg[3:2])
        pulse(8);
        `CHK("send_act", 1'b1, state_reg[5])
        pulse(7);
        `CHK("frame_in", 2'b01, state_reg[5:4])
        rdc(8'h0c, 8'h02);
        wr(8'h04, 8'h10);
        wr(8'h04, 8'h00);
        rdc(8'h0c, 8'h10);
    endtask
    task automatic t_fault;
        core.warn_level <= 1'b1;
        repeat (3) @(posedge aclk);
        rdc(8'h0c, 8'h04);
    endtask
    task automatic t_busoff;
        core.warn_level <= 1'b0;
        rdc(8'h0c, 8'h04);
        pulse(1);
        pulse(4);
        pulse(8);
        `CHK("control", 8'h1f, control_reg)
        `CHK("command", 8'h0c, command_reg)
        `CHK("state", 8'h8c, state_reg)
        rdc(8'h0c, 8'h04);
        wr(8'h00, 8'h1e);
        repeat (3) pulse(0);
        `CHK("link_off", 1'b1, state_reg[7])
        pulse(0);
        `CHK("link_off", 2'b00, state_reg[7:6])
        `CHK("cnt_rst", 1'b1, counter_reset)
        @(posedge aclk) #1;
        `CHK("cnt_rst", 1'b0, counter_reset)
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_rx;
        t_tx;
        t_fault;
        t_busoff;
        finish_test;
    end
endmodule
